// File: rtl/asp_pkg.sv
// package for the async sram word port controller: pin bundle, timing counts, states
package asp_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_PS = 4000;
    // slowest speed grade figures, in ps
    localparam int ADDRESS_ACCESS_TIME_PS = 15000;
    localparam int SELECT_ACCESS_TIME_PS = 15000;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_PS = 7000;
    localparam int BYTE_ENABLE_ACCESS_TIME_PS = 7000;
    localparam int BYTE_ENABLE_WRITE_WIDTH_PS = 9000;
    localparam int ADDRESS_TO_WRITE_END_PS = 10000;
    localparam int SELECT_TO_WRITE_END_PS = 10000;
    localparam int DATA_SETUP_PS = 8000;
    localparam int DESELECT_TO_STANDBY_PS = 15000;
    localparam int OUTPUT_DISABLE_PS = 7000;
    // least times round up; reads add two cycles, one for each pin input flop
    localparam int RD_CYCLES = (ADDRESS_ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 2;
    localparam int WR_A = (ADDRESS_TO_WRITE_END_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_B = (BYTE_ENABLE_WRITE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_C = (SELECT_TO_WRITE_END_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_AB = (WR_A > WR_B) ? WR_A : WR_B;
    localparam int WR_CYCLES = (WR_AB > WR_C) ? WR_AB : WR_C;
    localparam int TURN_CYCLES = (OUTPUT_DISABLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYCLES - 1);
    localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYCLES - 1);
    localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [1:0] BE_NONE = 2'h3;

    typedef struct packed {
        logic chip_select_n;
        logic output_enable_n;
        logic write_strobe_n;
        logic lower_byte_enable_n;
        logic upper_byte_enable_n;
        logic [ADDR_W-1:0] addr;
    } asp_ctl_s;

    typedef struct packed {
        logic write;
        logic [1:0] byte_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asp_req_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_TURN = 4'b1000
    } asp_state_e;
endpackage

// File: rtl/asp_ctrl.sv
// controller that drives an asynchronous 64k x 16 static memory over its pins
`timescale 1ns/1ps
module asp_ctrl
    import asp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // user request
    input wire logic req_valid_in,
    input asp_pkg::asp_req_s req_in,
    output logic req_ready_out,
    // user read answer
    output logic rsp_valid_out,
    output logic [asp_pkg::DATA_W-1:0] rsp_data_out,
    // memory pins
    output asp_pkg::asp_ctl_s mem_ctl_out,
    input wire logic [asp_pkg::DATA_W-1:0] mem_data_in,
    output logic [asp_pkg::DATA_W-1:0] mem_data_out,
    output logic [1:0] mem_data_oe_n_out
);
    import asp_pkg::*;

    asp_state_e state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    asp_ctl_s ctl_r, ctl_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [1:0] oe_n_r, oe_n_nxt;
    logic [1:0] be_r, be_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [DATA_W-1:0] rsp_data_r, rsp_data_nxt;
    logic [DATA_W-1:0] sync1_r, sync2_r;
    logic [DATA_W-1:0] sync1_nxt, sync2_nxt;
    logic capture;
    logic [7:0] lane_pick [0:1];

    // the first flop may settle late, so logic reads only the second
    always_comb
    begin
        sync1_nxt = mem_data_in;
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge sys_clk_in)
    begin
        sync1_r <= sync1_nxt;
        sync2_r <= sync2_nxt;
    end

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ctl_nxt = ctl_r;
        wdata_nxt = wdata_r;
        oe_n_nxt = oe_n_r;
        be_nxt = be_r;
        case (state_r)
            ST_IDLE:
            begin
                // a request with no byte enabled is consumed but never touches the pins
                if (req_valid_in && req_in.byte_en != 2'h0)
                begin
                    ctl_nxt.addr = req_in.addr;
                    ctl_nxt.chip_select_n = 1'b0;
                    ctl_nxt.lower_byte_enable_n = ~req_in.byte_en[0];
                    ctl_nxt.upper_byte_enable_n = ~req_in.byte_en[1];
                    be_nxt = req_in.byte_en;
                    if (req_in.write)
                    begin
                        // strobe, select and byte enables fall together, data lanes driven on the same edge
                        ctl_nxt.write_strobe_n = 1'b0;
                        ctl_nxt.output_enable_n = 1'b1;
                        wdata_nxt = req_in.wdata;
                        oe_n_nxt = ~req_in.byte_en;
                        cnt_nxt = WR_CNT;
                        state_nxt = ST_WRITE;
                    end
                    else
                    begin
                        ctl_nxt.write_strobe_n = 1'b1;
                        ctl_nxt.output_enable_n = 1'b0;
                        oe_n_nxt = BE_NONE;
                        cnt_nxt = RD_CNT;
                        state_nxt = ST_READ;
                    end
                end
            end
            ST_READ:
            begin
                if (cnt_r == CNT_ZERO)
                begin
                    ctl_nxt.chip_select_n = 1'b1;
                    ctl_nxt.output_enable_n = 1'b1;
                    ctl_nxt.lower_byte_enable_n = 1'b1;
                    ctl_nxt.upper_byte_enable_n = 1'b1;
                    // wait for memory to release the bus before we may drive it
                    cnt_nxt = TURN_CNT;
                    state_nxt = ST_TURN;
                end
                else
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_WRITE:
            begin
                if (cnt_r == CNT_ZERO)
                begin
                    // all terminating edges together; data and address stay one more cycle
                    ctl_nxt.chip_select_n = 1'b1;
                    ctl_nxt.write_strobe_n = 1'b1;
                    ctl_nxt.lower_byte_enable_n = 1'b1;
                    ctl_nxt.upper_byte_enable_n = 1'b1;
                    cnt_nxt = CNT_ZERO;
                    state_nxt = ST_TURN;
                end
                else
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_TURN:
            begin
                oe_n_nxt = BE_NONE;
                if (cnt_r == CNT_ZERO)
                begin
                    state_nxt = ST_IDLE;
                end
                else
                begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
            ctl_r <= '{chip_select_n: 1'b1, output_enable_n: 1'b1, write_strobe_n: 1'b1,
                       lower_byte_enable_n: 1'b1, upper_byte_enable_n: 1'b1, addr: 16'h0000};
            wdata_r <= 16'h0000;
            oe_n_r <= BE_NONE;
            be_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ctl_r <= ctl_nxt;
            wdata_r <= wdata_nxt;
            oe_n_r <= oe_n_nxt;
            be_r <= be_nxt;
        end
    end

    // read answer: taken a full access time plus two sync flops after the pins settled
    assign capture = (state_r == ST_READ) && (cnt_r == CNT_ZERO);

    // one capture mux per byte lane; a lane not enabled reads as zero
    genvar lane;
    generate
        for (lane = 0; lane < DATA_W / 8; lane = lane + 1)
        begin : g_lane
            // sampled before address or controls change
            assign lane_pick[lane] = be_r[lane] ? sync2_r[lane*8 +: 8] : 8'h00;
        end
    endgenerate

    always_comb
    begin
        rsp_valid_nxt = capture;
        rsp_data_nxt = rsp_data_r;
        if (capture)
        begin
            rsp_data_nxt = {lane_pick[1], lane_pick[0]};
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 16'h0000;
        end
        else
        begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
        end
    end

    assign req_ready_out = (state_r == ST_IDLE);
    assign rsp_valid_out = rsp_valid_r;
    assign rsp_data_out = rsp_data_r;
    assign mem_ctl_out = ctl_r;
    assign mem_data_out = wdata_r;
    assign mem_data_oe_n_out = oe_n_r;
endmodule // asp_ctrl

// File: tb/asp_ctrl_properties.sv
// pin timing and handshake assertions for the sram port controller
`timescale 1ns/1ps
module asp_ctrl_properties
    import asp_pkg::*;
(
    // watched ports
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic req_valid_in,
    input asp_pkg::asp_req_s req_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input asp_pkg::asp_ctl_s mem_ctl_out,
    input wire logic [asp_pkg::DATA_W-1:0] mem_data_out,
    input wire logic [1:0] mem_data_oe_n_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    wire logic cs_n = mem_ctl_out.chip_select_n;
    wire logic we_n = mem_ctl_out.write_strobe_n;
    wire logic lbe_n = mem_ctl_out.lower_byte_enable_n;
    wire logic ube_n = mem_ctl_out.upper_byte_enable_n;
    wr_byte_en_a: assert property (!cs_n && !we_n |-> !(lbe_n && ube_n))
        else $error("write strobe with no byte enable");
    rd_strobe_high_a: assert property (!cs_n && !mem_ctl_out.output_enable_n |-> we_n)
        else $error("write strobe low during read");
    no_bus_fight_a: assert property (!mem_ctl_out.output_enable_n |-> mem_data_oe_n_out == 2'h3)
        else $error("controller drives lanes while memory may");
    lane_match_a: assert property (!we_n |-> mem_data_oe_n_out == {ube_n, lbe_n})
        else $error("driven lanes differ from byte enables");
    wr_width_a: assert property ($fell(we_n) |-> !we_n [*3] ##1 we_n)
        else $error("write strobe width wrong");
    end_together_a: assert property ($rose(we_n) |-> $rose(cs_n) && lbe_n && ube_n)
        else $error("write end strobes not together");
    wr_hold_a: assert property ($rose(we_n) |-> $stable(mem_data_out) && $stable(mem_ctl_out.addr))
        else $error("data or address moved at write end");
    rd_answer_a: assert property (req_valid_in && req_ready_out && !req_in.write && req_in.byte_en != 2'h0
        |-> ##7 rsp_valid_out)
        else $error("read answer late or missing");
endmodule // asp_ctrl_properties

bind asp_ctrl asp_ctrl_properties asp_ctrl_properties_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .mem_ctl_out(mem_ctl_out), .mem_data_out(mem_data_out), .mem_data_oe_n_out(mem_data_oe_n_out));

// File: tb/asp_mem_model.sv
// behavioural model of the 64k x 16 asynchronous static memory
`timescale 1ns/1ps
module asp_mem_model
    import asp_pkg::*;
#(
    parameter int ACC_NS = 15,
    parameter int EN_NS = 7
)
(
    // pins from the controller
    input asp_pkg::asp_ctl_s ctl_in,
    input wire logic [asp_pkg::DATA_W-1:0] bus_in,
    // lanes toward the controller
    output logic [asp_pkg::DATA_W-1:0] data_out
);
    logic [15:0] mem [0:65535];
    logic [15:0] junk = 16'h5a5a;
    logic [15:0] rd_dly;
    logic [1:0] wen, ren, drv_dly;
    // released lanes toggle so a stale value never looks valid
    always #3 junk = ~junk;
    assign wen = (!ctl_in.chip_select_n && !ctl_in.write_strobe_n) ?
        ~{ctl_in.upper_byte_enable_n, ctl_in.lower_byte_enable_n} : 2'h0;
    always @*
    begin
        if (wen[0])
            mem[ctl_in.addr][7:0] = bus_in[7:0];
        if (wen[1])
            mem[ctl_in.addr][15:8] = bus_in[15:8];
    end
    assign ren = (!ctl_in.chip_select_n && !ctl_in.output_enable_n && ctl_in.write_strobe_n) ?
        ~{ctl_in.upper_byte_enable_n, ctl_in.lower_byte_enable_n} : 2'h0;
    assign #(ACC_NS) rd_dly = mem[ctl_in.addr];
    assign #(EN_NS) drv_dly = ren;
    assign data_out = {drv_dly[1] ? rd_dly[15:8] : junk[15:8], drv_dly[0] ? rd_dly[7:0] : junk[7:0]};
endmodule // asp_mem_model

// File: tb/asp_ctrl_tb_top.sv
// self-checking bench for the async sram word port controller
`timescale 1ns/1ps
module asp_ctrl_tb_top;
    import asp_pkg::*;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic req_valid_in = 1'b0;
    asp_req_s req_in = '0;
    logic req_ready_out, rsp_valid_out;
    logic [15:0] rsp_data_out, mem_data_in, mem_data_out, bus;
    logic [1:0] mem_data_oe_n_out;
    asp_ctl_s mem_ctl_out;
    logic [15:0] shadow [0:7];
    logic [15:0] exp_q [$];
    logic [31:0] lfsr = 32'h313b_5f14;
    int failures = 0;
    int total_checks = 0;
    asp_ctrl asp_ctrl_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
        .mem_ctl_out(mem_ctl_out), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
        .mem_data_oe_n_out(mem_data_oe_n_out));
    asp_mem_model asp_mem_model_i (.ctl_in(mem_ctl_out), .bus_in(bus), .data_out(mem_data_in));
    // lanes the controller releases show inverted data
    assign bus = mem_data_out ^ {{8{mem_data_oe_n_out[1]}}, {8{mem_data_oe_n_out[0]}}};
    initial forever #2 sys_clk_in = ~sys_clk_in;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: read %h, want %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic issue(input logic wr, input logic [1:0] be, input logic [2:0] idx, input logic [15:0] d);
        int n;
        @(negedge sys_clk_in);
        req_valid_in = 1'b1;
        req_in = '{wr, be, 16'(idx) * 16'h2492, d};
        for (n = 0; req_ready_out !== 1'b1 && n < 50; n++)
            @(negedge sys_clk_in);
        if (n == 50)
        begin
            failures++;
            $display("unexpected at %0t: request never taken", $time);
        end
        @(negedge sys_clk_in);
        req_valid_in = 1'b0;
        if (!wr && be != 2'h0)
            exp_q.push_back(shadow[idx] & {{8{be[1]}}, {8{be[0]}}});
        if (wr && be[0])
            shadow[idx][7:0] = d[7:0];
        if (wr && be[1])
            shadow[idx][15:8] = d[15:8];
    endtask
    always @(negedge sys_clk_in)
        if (rsp_valid_out === 1'b1)
            check(rsp_data_out, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
    initial
    begin
        #20000;
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out;
    end
    initial
    begin
        repeat (3) @(negedge sys_clk_in);
        resetn_in = 1'b1;
        for (int i = 0; i < 8; i++)
            issue(1'b1, 2'h3, 3'(i), 16'(i) * 16'h1111);
        for (int i = 0; i < 90; i++)
        begin
            lfsr = lfsr_next(lfsr);
            issue(lfsr[0], lfsr[2:1], lfsr[5:3], lfsr[21:6]);
        end
        for (int n = 0; n < 20 && exp_q.size() > 0; n++)
            @(negedge sys_clk_in);
        if (exp_q.size() != 0)
        begin
            failures++;
            $display("unexpected at %0t: %0d reads never answered", $time, exp_q.size());
        end
        close_out;
    end
endmodule // asp_ctrl_tb_top
